// file: logic/cfg_bank_pkg.sv
// Purpose: constants shared by the configuration register bank
// Assumes: 10-bit host I/O addresses, 8-bit data, 10 MHz mclk
// Notes: offsets are index values seen through the data port
//
// Behaviour
// R01 - index written at port F2, then port F3 reads/writes selected register
// R02 - serial control bit 1 set disables second serial channel; reset 0
// R03 - serial control bit 0 powers down second channel; reset from strap
// R04 - primary serial base bits 7-1 hold A9-3 of first window, default FE
// R05 - primary serial base bit 0 set adds A2 to parallel port decode
// R06 - secondary serial base bits 7-1 hold A9-3, default BE, bit 0 reserved
// R07 - irq3 from bits 7-6, irq4 from 5-4; 01 parallel, 10 first, 11 second
// R08 - irq7 from bits 3-2, irq5 from 1-0; 01 second, 10 parallel, 11 first
// R09 - dma select bits 5-4: 00 drq0, 01 drq1, 10 off, 11 drq3
// R10 - fifo code n gives read threshold 15-n, write threshold n+1; the code treats 1111 as 1110
// R11 - floppy control bit 6 swaps drive selects 0 and 1
// R12 - floppy control bit 3 stops the floppy controller clock
// R13 - floppy control bit 1 disables floppy controller; reset from strap
// R14 - floppy control bit 0 picks secondary floppy address when set
// R15 - disk control bit 3 decodes both disk channels
// R16 - disk control bit 2 picks the 8-bit host interface style
// R17 - disk control bit 1 disables disk chip selects; reset from strap
// R18 - disk control bit 0 picks the secondary disk channel address set
// R19 - reserved bits read as zero and ignore writes
package cfg_bank_pkg;
    // host ports
    localparam logic [9:0] PORT_INDEX = 10'h0F2;
    localparam logic [9:0] PORT_DATA = 10'h0F3;
    // register indexes
    localparam logic [7:0] IDX_SER_CTL = 8'hDB;
    localparam logic [7:0] IDX_SER_A_BASE = 8'hDC;
    localparam logic [7:0] IDX_SER_B_BASE = 8'hDD;
    localparam logic [7:0] IDX_IRQ_ROUTE = 8'hDE;
    localparam logic [7:0] IDX_DMA_FIFO = 8'hDF;
    localparam logic [7:0] IDX_FLP_CTL = 8'hFB;
    localparam logic [7:0] IDX_DISK_CTL = 8'hFE;
    // writable-bit masks, everything else is reserved
    localparam logic [7:0] MASK_SER_CTL = 8'h03;
    localparam logic [7:0] MASK_SER_B_BASE = 8'hFE;
    localparam logic [7:0] MASK_DMA_FIFO = 8'h3F;
    localparam logic [7:0] MASK_FLP_CTL = 8'h4B;
    localparam logic [7:0] MASK_DISK_CTL = 8'h0F;
    // values after reset, and the value read at an unmapped index
    localparam logic [7:0] RST_SER_A_BASE = 8'hFE;
    localparam logic [7:0] RST_SER_B_BASE = 8'hBE;
    localparam logic [7:0] RST_IRQ_ROUTE = 8'hE2;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;
    // field positions
    localparam int SER_B_DIS = 1;
    localparam int SER_B_PD = 0;
    localparam int SER_A_A2 = 0;
    localparam int FLP_SWAP = 6;
    localparam int FLP_CLKDIS = 3;
    localparam int FLP_DIS = 1;
    localparam int FLP_SEC = 0;
    localparam int DISK_BOTH = 3;
    localparam int DISK_8BIT = 2;
    localparam int DISK_DIS = 1;
    localparam int DISK_SEC = 0;
    // dma select codes
    localparam logic [1:0] DRQ_SEL_0 = 2'h0;
    localparam logic [1:0] DRQ_SEL_1 = 2'h1;
    localparam logic [1:0] DRQ_SEL_OFF = 2'h2;
    // disk channel windows, address bits 9-3
    localparam logic [6:0] DISK_PRI_WIN = 7'h3E;
    localparam logic [6:0] DISK_SEC_WIN = 7'h2E;
    // straps are loaded once the synchroniser has filled
    localparam logic [1:0] STRAP_LOAD_CNT = 2'h2;
endpackage : cfg_bank_pkg

// file: logic/irq_source_select.sv
// Purpose: pick one interrupt source for one host interrupt line
// Assumes: sources are levels on mclk
// Notes: ALT_MAP chooses the code table of lines 7 and 5
`timescale 1ns/1ns
`default_nettype none
module irq_source_select #(
    parameter bit ALT_MAP = 1'b0
) (
    // select code
    input wire logic [1:0] sel,
    // candidate sources
    input wire logic par_irq,
    input wire logic ser_a_irq,
    input wire logic ser_b_irq,
    // chosen line
    output logic irq
);
    // code 00 always parks the line low
    always_comb
    begin
        case (sel)
            2'h1: irq = ALT_MAP ? ser_b_irq : par_irq;
            2'h2: irq = ALT_MAP ? par_irq : ser_a_irq;
            2'h3: irq = ALT_MAP ? ser_a_irq : ser_b_irq;
            default: irq = 1'b0;
        endcase
    end
endmodule : irq_source_select
`default_nettype wire

// file: logic/fifo_threshold_decode.sv
// Purpose: turn the fifo code into read and write thresholds
// Assumes: code comes from a register on mclk
// Notes: code 1111 is clamped so that it still gives 1 and 15
`timescale 1ns/1ns
`default_nettype none
module fifo_threshold_decode (
    // code
    input wire logic [3:0] code,
    // thresholds
    output logic [3:0] rd_thresh,
    output logic [3:0] wr_thresh
);
    logic [3:0] eff;
    // the table skips 1110 and maps all-ones to 1/15, so clamp to 14
    assign eff = (code == 4'hF) ? 4'hE : code;
    assign rd_thresh = 4'hF - eff; // R10
    assign wr_thresh = eff + 4'h1; // R10
endmodule : fifo_threshold_decode
`default_nettype wire

// file: logic/cfg_register_bank.sv
// Purpose: indexed configuration bank for the peripheral I/O section
// Assumes: host bus pins are asynchronous to mclk and held for many cycles
// Notes: a write takes effect when the write strobe rises
`timescale 1ns/1ns
`default_nettype none
module cfg_register_bank (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // host i/o cycle pins
    input wire logic [9:0] sa,
    input wire logic aen,
    input wire logic ior_n,
    input wire logic iow_n,
    input wire logic [7:0] sd_in,
    output logic [7:0] sd_out,
    output logic sd_oe_n,
    // power-up straps
    input wire logic strap_ser_b_pd,
    input wire logic strap_flp_dis,
    input wire logic strap_disk_dis,
    // interrupt sources from the peripherals
    input wire logic par_irq,
    input wire logic ser_a_irq,
    input wire logic ser_b_irq,
    // host interrupt lines
    output logic irq3,
    output logic irq4,
    output logic irq5,
    output logic irq7,
    // extended parallel mode dma
    input wire logic xpm_drq,
    output logic drq0,
    output logic drq1,
    output logic drq3,
    output logic [3:0] xpm_rd_thresh,
    output logic [3:0] xpm_wr_thresh,
    // serial channels
    output logic ser_a_cs,
    output logic ser_b_cs,
    output logic ser_b_disable,
    output logic ser_b_powerdown,
    output logic par_a2_decode,
    // floppy controller
    input wire logic [1:0] flp_ds_in,
    output logic [1:0] flp_ds_out,
    output logic flp_clk_en,
    output logic flp_disable,
    output logic flp_secondary,
    // disk interface
    output logic disk_cs_pri,
    output logic disk_cs_sec,
    output logic disk_8bit_style
);
    typedef struct packed {
        logic iow1;
        logic iow2;
        logic iow3;
        logic ior1;
        logic ior2;
        logic aen1;
        logic aen2;
        logic aen3;
        logic [9:0] sa1;
        logic [9:0] sa2;
        logic [9:0] sa3;
        logic [7:0] d1;
        logic [7:0] d2;
        logic [7:0] d3;
        logic [2:0] strap1;
        logic [2:0] strap2;
        logic [1:0] strap_cnt;
        logic [7:0] index;
        logic [7:0] ser_ctl;
        logic [7:0] ser_a_base;
        logic [7:0] ser_b_base;
        logic [7:0] irq_route;
        logic [7:0] dma_fifo;
        logic [7:0] flp_ctl;
        logic [7:0] disk_ctl;
        logic [7:0] rdata;
        logic drive;
    } bank_state_t;

    bank_state_t st_r;
    bank_state_t st_nxt;
    logic wr_evt;
    logic rd_sel;
    logic [7:0] rd_mux;
    logic [3:0] irq_lines;

    // a write ends on the rising strobe; address and data are one stage older
    assign wr_evt = st_r.iow2 && !st_r.iow3 && !st_r.aen3;
    assign rd_sel = !st_r.ior2 && !st_r.aen2 && st_r.sa2 == cfg_bank_pkg::PORT_DATA;

    // read mux; unwritable bits are already zero in the stored copies
    always_comb
    begin
        case (st_r.index)
            cfg_bank_pkg::IDX_SER_CTL: rd_mux = st_r.ser_ctl;
            cfg_bank_pkg::IDX_SER_A_BASE: rd_mux = st_r.ser_a_base;
            cfg_bank_pkg::IDX_SER_B_BASE: rd_mux = st_r.ser_b_base;
            cfg_bank_pkg::IDX_IRQ_ROUTE: rd_mux = st_r.irq_route;
            cfg_bank_pkg::IDX_DMA_FIFO: rd_mux = st_r.dma_fifo;
            cfg_bank_pkg::IDX_FLP_CTL: rd_mux = st_r.flp_ctl;
            cfg_bank_pkg::IDX_DISK_CTL: rd_mux = st_r.disk_ctl;
            default: rd_mux = cfg_bank_pkg::RD_UNMAPPED;
        endcase
    end

    // next state: synchronisers, strap load, register writes, read data
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.iow1 = iow_n;
        st_nxt.iow2 = st_r.iow1;
        st_nxt.iow3 = st_r.iow2;
        st_nxt.ior1 = ior_n;
        st_nxt.ior2 = st_r.ior1;
        st_nxt.aen1 = aen;
        st_nxt.aen2 = st_r.aen1;
        st_nxt.aen3 = st_r.aen2;
        st_nxt.sa1 = sa;
        st_nxt.sa2 = st_r.sa1;
        st_nxt.sa3 = st_r.sa2;
        st_nxt.d1 = sd_in;
        st_nxt.d2 = st_r.d1;
        st_nxt.d3 = st_r.d2;
        st_nxt.strap1 = {strap_disk_dis, strap_flp_dis, strap_ser_b_pd};
        st_nxt.strap2 = st_r.strap1;
        // straps land once, after the synchroniser holds real pin levels
        if (st_r.strap_cnt != 2'h3)
        begin
            st_nxt.strap_cnt = st_r.strap_cnt + 2'h1;
        end
        if (st_r.strap_cnt == cfg_bank_pkg::STRAP_LOAD_CNT)
        begin
            st_nxt.ser_ctl[cfg_bank_pkg::SER_B_PD] = st_r.strap2[0]; // R03
            st_nxt.flp_ctl[cfg_bank_pkg::FLP_DIS] = st_r.strap2[1]; // R13
            st_nxt.disk_ctl[cfg_bank_pkg::DISK_DIS] = st_r.strap2[2]; // R17
        end
        // index port is write-only; data port goes to the indexed register
        if (wr_evt && st_r.sa3 == cfg_bank_pkg::PORT_INDEX)
        begin
            st_nxt.index = st_r.d3; // R01
        end
        if (wr_evt && st_r.sa3 == cfg_bank_pkg::PORT_DATA)
        begin
            case (st_r.index) // R01
                cfg_bank_pkg::IDX_SER_CTL:
                    st_nxt.ser_ctl = st_r.d3 & cfg_bank_pkg::MASK_SER_CTL; // R19
                cfg_bank_pkg::IDX_SER_A_BASE:
                    st_nxt.ser_a_base = st_r.d3; // R04
                cfg_bank_pkg::IDX_SER_B_BASE:
                    st_nxt.ser_b_base = st_r.d3 & cfg_bank_pkg::MASK_SER_B_BASE; // R06
                cfg_bank_pkg::IDX_IRQ_ROUTE:
                    st_nxt.irq_route = st_r.d3;
                cfg_bank_pkg::IDX_DMA_FIFO:
                    st_nxt.dma_fifo = st_r.d3 & cfg_bank_pkg::MASK_DMA_FIFO; // R19
                cfg_bank_pkg::IDX_FLP_CTL:
                    st_nxt.flp_ctl = st_r.d3 & cfg_bank_pkg::MASK_FLP_CTL; // R19
                cfg_bank_pkg::IDX_DISK_CTL:
                    st_nxt.disk_ctl = st_r.d3 & cfg_bank_pkg::MASK_DISK_CTL; // R19
                default:
                    st_nxt.index = st_r.index;
            endcase
        end
        // read data is held in a flop; it follows the index while driven
        st_nxt.rdata = rd_mux; // R01
        st_nxt.drive = rd_sel;
    end

    // the only clocked process; reset loads constants only
    always_ff @(posedge mclk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
            st_r.iow1 <= 1'b1;
            st_r.iow2 <= 1'b1;
            st_r.iow3 <= 1'b1;
            st_r.ior1 <= 1'b1;
            st_r.ior2 <= 1'b1;
            st_r.aen1 <= 1'b1;
            st_r.aen2 <= 1'b1;
            st_r.aen3 <= 1'b1;
            st_r.ser_ctl <= cfg_bank_pkg::RST_ZERO;
            st_r.ser_a_base <= cfg_bank_pkg::RST_SER_A_BASE;
            st_r.ser_b_base <= cfg_bank_pkg::RST_SER_B_BASE;
            st_r.irq_route <= cfg_bank_pkg::RST_IRQ_ROUTE;
            st_r.dma_fifo <= cfg_bank_pkg::RST_ZERO;
            st_r.flp_ctl <= cfg_bank_pkg::RST_ZERO;
            st_r.disk_ctl <= cfg_bank_pkg::RST_ZERO;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // host data bus, enable is low while driving
    assign sd_out = st_r.rdata;
    assign sd_oe_n = !st_r.drive;

    // four interrupt lines: 3 and 4 share one code table, 7 and 5 the other
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_irq
            irq_source_select #(
                .ALT_MAP(g >= 2)
            ) u_sel (
                .sel(st_r.irq_route[7 - 2 * g -: 2]), // R07 R08
                .par_irq(par_irq),
                .ser_a_irq(ser_a_irq),
                .ser_b_irq(ser_b_irq),
                .irq(irq_lines[g])
            );
        end
    endgenerate
    assign irq3 = irq_lines[0]; // R07
    assign irq4 = irq_lines[1]; // R07
    assign irq7 = irq_lines[2]; // R08
    assign irq5 = irq_lines[3]; // R08

    // dma request steering; code 10 parks every line low
    assign drq0 = xpm_drq && st_r.dma_fifo[5:4] == cfg_bank_pkg::DRQ_SEL_0; // R09
    assign drq1 = xpm_drq && st_r.dma_fifo[5:4] == cfg_bank_pkg::DRQ_SEL_1; // R09
    assign drq3 = xpm_drq && st_r.dma_fifo[5:4] == 2'h3; // R09

    fifo_threshold_decode u_thresh (
        .code(st_r.dma_fifo[3:0]),
        .rd_thresh(xpm_rd_thresh),
        .wr_thresh(xpm_wr_thresh)
    );

    // serial windows decode from the synced address, not the raw pins
    assign ser_b_disable = st_r.ser_ctl[cfg_bank_pkg::SER_B_DIS]; // R02
    assign ser_b_powerdown = st_r.ser_ctl[cfg_bank_pkg::SER_B_PD]; // R03
    assign par_a2_decode = st_r.ser_a_base[cfg_bank_pkg::SER_A_A2]; // R05
    assign ser_a_cs = !st_r.aen3 && st_r.sa3[9:3] == st_r.ser_a_base[7:1]; // R04
    assign ser_b_cs = !st_r.aen3 && !ser_b_disable
        && st_r.sa3[9:3] == st_r.ser_b_base[7:1]; // R06 R02

    // floppy controls
    assign flp_ds_out = st_r.flp_ctl[cfg_bank_pkg::FLP_SWAP]
        ? {flp_ds_in[0], flp_ds_in[1]} : flp_ds_in; // R11
    assign flp_clk_en = !st_r.flp_ctl[cfg_bank_pkg::FLP_CLKDIS]; // R12
    assign flp_disable = st_r.flp_ctl[cfg_bank_pkg::FLP_DIS]; // R13
    assign flp_secondary = st_r.flp_ctl[cfg_bank_pkg::FLP_SEC]; // R14

    // disk chip selects; with both set the channel bit no longer matters
    logic disk_on;
    logic in_pri;
    logic in_sec;
    assign disk_on = !st_r.aen3 && !st_r.disk_ctl[cfg_bank_pkg::DISK_DIS]; // R17
    assign in_pri = st_r.sa3[9:3] == cfg_bank_pkg::DISK_PRI_WIN;
    assign in_sec = st_r.sa3[9:3] == cfg_bank_pkg::DISK_SEC_WIN;
    assign disk_cs_pri = disk_on && in_pri && (st_r.disk_ctl[cfg_bank_pkg::DISK_BOTH]
        || !st_r.disk_ctl[cfg_bank_pkg::DISK_SEC]); // R15 R18
    assign disk_cs_sec = disk_on && in_sec && (st_r.disk_ctl[cfg_bank_pkg::DISK_BOTH]
        || st_r.disk_ctl[cfg_bank_pkg::DISK_SEC]); // R15 R18
    assign disk_8bit_style = st_r.disk_ctl[cfg_bank_pkg::DISK_8BIT]; // R16

    // checks
    sequence s_data_wr_flp;
        wr_evt && st_r.sa3 == cfg_bank_pkg::PORT_DATA
            && st_r.index == cfg_bank_pkg::IDX_FLP_CTL;
    endsequence

    property p_index_write;
        @(posedge mclk) disable iff (sys_rst)
        wr_evt && st_r.sa3 == cfg_bank_pkg::PORT_INDEX
            |=> st_r.index == $past(st_r.d3);
    endproperty
    a_index_write: assert property (p_index_write) // R01
        else $error("index port write not captured");

    property p_flp_reserved;
        @(posedge mclk) disable iff (sys_rst)
        s_data_wr_flp |=> (st_r.flp_ctl & ~cfg_bank_pkg::MASK_FLP_CTL) == 8'h00
            ##0 flp_clk_en == !$past(st_r.d3[cfg_bank_pkg::FLP_CLKDIS]);
    endproperty
    a_flp_reserved: assert property (p_flp_reserved) // R19
        else $error("floppy write stored reserved bits or lost clock bit");

    property p_swap;
        @(posedge mclk) disable iff (sys_rst)
        st_r.flp_ctl[cfg_bank_pkg::FLP_SWAP] |-> flp_ds_out == {flp_ds_in[0], flp_ds_in[1]};
    endproperty
    a_swap: assert property (p_swap) // R11
        else $error("drive selects not swapped");

    property p_thresh_sum;
        @(posedge mclk) disable iff (sys_rst)
        st_r.dma_fifo[3:0] != 4'hF |-> 5'(xpm_rd_thresh) + 5'(xpm_wr_thresh) == 5'h10
            && xpm_wr_thresh == st_r.dma_fifo[3:0] + 4'h1;
    endproperty
    a_thresh_sum: assert property (p_thresh_sum) // R10
        else $error("fifo thresholds wrong");

    property p_drq_off;
        @(posedge mclk) disable iff (sys_rst)
        st_r.dma_fifo[5:4] == cfg_bank_pkg::DRQ_SEL_OFF |-> !(drq0 || drq1 || drq3);
    endproperty
    a_drq_off: assert property (p_drq_off) // R09
        else $error("dma request driven while disabled");

    property p_ser_b_gate;
        @(posedge mclk) disable iff (sys_rst)
        st_r.ser_ctl[cfg_bank_pkg::SER_B_DIS] |-> !ser_b_cs;
    endproperty
    a_ser_b_gate: assert property (p_ser_b_gate) // R02
        else $error("second serial window decoded while disabled");

    property p_strap_load;
        @(posedge mclk) disable iff (sys_rst)
        st_r.strap_cnt == cfg_bank_pkg::STRAP_LOAD_CNT
            |=> flp_disable == $past(st_r.strap2[1])
            && ser_b_powerdown == $past(st_r.strap2[0]);
    endproperty
    a_strap_load: assert property (p_strap_load) // R13 R03
        else $error("strap not loaded at power-up");

    property p_irq3_route;
        @(posedge mclk) disable iff (sys_rst)
        st_r.irq_route[7:6] == 2'h2 |-> irq3 == ser_a_irq;
    endproperty
    a_irq3_route: assert property (p_irq3_route) // R07
        else $error("irq3 not following first serial channel");

    property p_disk_dis;
        @(posedge mclk) disable iff (sys_rst)
        st_r.disk_ctl[cfg_bank_pkg::DISK_DIS] |-> !disk_cs_pri && !disk_cs_sec;
    endproperty
    a_disk_dis: assert property (p_disk_dis) // R17
        else $error("disk chip select while disabled");

    property p_read_drive;
        @(posedge mclk) disable iff (sys_rst)
        rd_sel ##1 rd_sel |=> !sd_oe_n && sd_out == $past(rd_mux);
    endproperty
    a_read_drive: assert property (p_read_drive) // R01
        else $error("data port read not driven");
endmodule : cfg_register_bank
`default_nettype wire

// file: verification/host_io_model.sv
// Purpose: behavioural host that issues i/o cycles to the config bank
// Assumes: one cycle at a time; pins change only at falling mclk
// Notes: released lines show the inverse of their last value, so a
//        decoder that samples too late sees garbage, not a stale match
`timescale 1ns/1ns
`default_nettype none
module host_io_model (
    // clock
    input wire logic mclk,
    // host i/o cycle pins
    output logic [9:0] sa,
    output logic aen,
    output logic ior_n,
    output logic iow_n,
    output logic [7:0] sd_in,
    input wire logic [7:0] sd_out,
    input wire logic sd_oe_n
);
    // idle bus at time zero
    initial
    begin
        sa = 10'h000;
        aen = 1'b0;
        ior_n = 1'b1;
        iow_n = 1'b1;
        sd_in = 8'h00;
    end

    // let n falling edges pass
    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask : idle

    // write: strobe low 5 cycles, address and data held 4 past the rise
    // because the device samples them three flops behind the strobe
    task automatic io_write(input logic [9:0] a, input logic [7:0] d,
                            input logic dma);
        @(negedge mclk);
        sa = a;
        aen = dma;
        sd_in = d;
        iow_n = 1'b0;
        idle(5);
        iow_n = 1'b1;
        idle(4);
        sa = ~a;
        sd_in = ~d;
        aen = 1'b0;
    endtask : io_write

    // read: bounded wait for the device to drive, drv tells the caller
    task automatic io_read(input logic [9:0] a, output logic [7:0] d,
                           output logic drv);
        @(negedge mclk);
        sa = a;
        ior_n = 1'b0;
        drv = 1'b0;
        for (int i = 0; i < 6 && !drv; i++)
        begin
            @(negedge mclk);
            drv = (sd_oe_n === 1'b0);
        end
        d = sd_out;
        ior_n = 1'b1;
        idle(4);
        sa = ~a;
    endtask : io_read

    // hold an address with no strobe so the synced decoders settle
    task automatic probe(input logic [9:0] a);
        @(negedge mclk);
        sa = a;
        idle(5);
    endtask : probe
endmodule : host_io_model
`default_nettype wire

// file: verification/tb_top.sv
// Purpose: self-checking bench for the configuration register bank
// Assumes: host cycles come from the host_io_model instance
// Notes: a shadow copy of the bank predicts every readback and output
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) chk(12'(g), 12'(e), `__LINE__)
module tb_top;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [9:0] sa;
    logic aen, ior_n, iow_n, sd_oe_n, xpm_drq = 1'b0;
    logic [7:0] sd_in, sd_out, d;
    logic [2:0] strap = 3'h0;
    logic [2:0] irq_src = 3'h0; // parallel, serial a, serial b
    logic [1:0] ds_in = 2'h0;
    logic [1:0] ds_out;
    logic irq3, irq4, irq5, irq7, drq0, drq1, drq3, drv;
    logic [3:0] rd_th, wr_th;
    logic cs_a, cs_b, b_dis, b_pd, a2, clk_en, f_dis, f_sec;
    logic cs_pri, cs_sec, style8;
    logic [31:0] seed = 32'h3442;
    logic [7:0] shadow [7];
    logic [7:0] idx_tab [7] = '{cfg_bank_pkg::IDX_SER_CTL,
        cfg_bank_pkg::IDX_SER_A_BASE, cfg_bank_pkg::IDX_SER_B_BASE,
        cfg_bank_pkg::IDX_IRQ_ROUTE, cfg_bank_pkg::IDX_DMA_FIFO,
        cfg_bank_pkg::IDX_FLP_CTL, cfg_bank_pkg::IDX_DISK_CTL};
    logic [7:0] mask_tab [7] = '{8'h03, 8'hFF, 8'hFE, 8'hFF, 8'h3F,
        8'h4B, 8'h0F};
    int k;
    int errors = 0;
    int samples_checked = 0;

    // 100 ns clock
    always #50 mclk = ~mclk;

    cfg_register_bank DUT (.mclk(mclk), .sys_rst(sys_rst), .sa(sa),
        .aen(aen), .ior_n(ior_n), .iow_n(iow_n), .sd_in(sd_in),
        .sd_out(sd_out), .sd_oe_n(sd_oe_n), .strap_ser_b_pd(strap[0]),
        .strap_flp_dis(strap[1]), .strap_disk_dis(strap[2]),
        .par_irq(irq_src[0]), .ser_a_irq(irq_src[1]),
        .ser_b_irq(irq_src[2]), .irq3(irq3), .irq4(irq4), .irq5(irq5),
        .irq7(irq7), .xpm_drq(xpm_drq), .drq0(drq0), .drq1(drq1),
        .drq3(drq3), .xpm_rd_thresh(rd_th), .xpm_wr_thresh(wr_th),
        .ser_a_cs(cs_a), .ser_b_cs(cs_b), .ser_b_disable(b_dis),
        .ser_b_powerdown(b_pd), .par_a2_decode(a2), .flp_ds_in(ds_in),
        .flp_ds_out(ds_out), .flp_clk_en(clk_en), .flp_disable(f_dis),
        .flp_secondary(f_sec), .disk_cs_pri(cs_pri),
        .disk_cs_sec(cs_sec), .disk_8bit_style(style8));

    host_io_model HOST (.mclk(mclk), .sa(sa), .aen(aen), .ior_n(ior_n),
        .iow_n(iow_n), .sd_in(sd_in), .sd_out(sd_out), .sd_oe_n(sd_oe_n));

    // xorshift source, fixed seed keeps runs repeatable
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // expected interrupt line; alt is the table of lines 7 and 5
    function automatic logic pick(input logic [1:0] c, input logic alt);
        case (c)
            2'h1: return alt ? irq_src[2] : irq_src[0];
            2'h2: return alt ? irq_src[0] : irq_src[1];
            2'h3: return alt ? irq_src[1] : irq_src[2];
            default: return 1'b0;
        endcase
    endfunction : pick

    task automatic chk(input logic [11:0] g, e, input int ln);
        samples_checked++;
        if (g !== e)
        begin
            errors++;
            $display("BAD t=%0t line %0d got %h want %h", $time, ln, g, e);
        end
    endtask : chk

    task automatic wr(input int r, input logic [7:0] v);
        HOST.io_write(cfg_bank_pkg::PORT_INDEX, idx_tab[r], 1'b0);
        HOST.io_write(cfg_bank_pkg::PORT_DATA, v, 1'b0);
        shadow[r] = v & mask_tab[r];
    endtask : wr

    task automatic rd_check(input int r);
        HOST.io_write(cfg_bank_pkg::PORT_INDEX, idx_tab[r], 1'b0);
        HOST.io_read(cfg_bank_pkg::PORT_DATA, d, drv);
        `CHK({drv, d}, {1'b1, shadow[r]});
    endtask : rd_check

    // fresh random sources, then every configuration output
    task automatic check_outputs();
        logic [3:0] n;
        logic [2:0] dq;
        @(negedge mclk);
        {irq_src, xpm_drq, ds_in} = 6'(rnd());
        #1;
        n = (shadow[4][3:0] == 4'hF) ? 4'hE : shadow[4][3:0];
        dq = {shadow[4][5:4] == 2'h3, shadow[4][5:4] == 2'h1,
              shadow[4][5:4] == 2'h0};
        `CHK(irq3, pick(shadow[3][7:6], 1'b0));
        `CHK(irq4, pick(shadow[3][5:4], 1'b0));
        `CHK(irq7, pick(shadow[3][3:2], 1'b1));
        `CHK(irq5, pick(shadow[3][1:0], 1'b1));
        `CHK({drq3, drq1, drq0}, dq & {3{xpm_drq}});
        `CHK({rd_th, wr_th}, {4'hF - n, n + 4'h1});
        `CHK(ds_out, shadow[5][6] ? {ds_in[0], ds_in[1]} : ds_in);
        `CHK(clk_en, !shadow[5][3]);
        `CHK(f_dis, shadow[5][1]);
        `CHK(f_sec, shadow[5][0]);
        `CHK(style8, shadow[6][2]);
        `CHK(b_dis, shadow[0][1]);
        `CHK(b_pd, shadow[0][0]);
        `CHK(a2, shadow[1][0]);
    endtask : check_outputs

    // window hits for both serial channels and both disk channels
    task automatic decode_sweep();
        logic [9:0] a [4];
        logic both, sec, dis;
        a[0] = {shadow[1][7:1], 3'(rnd())};
        a[1] = {shadow[2][7:1], 3'(rnd())};
        a[2] = {cfg_bank_pkg::DISK_PRI_WIN, 3'h7};
        a[3] = {cfg_bank_pkg::DISK_SEC_WIN, 3'h0};
        {both, sec, dis} = {shadow[6][3], shadow[6][0], shadow[6][1]};
        foreach (a[j])
        begin
            HOST.probe(a[j]);
            `CHK(cs_a, a[j][9:3] == shadow[1][7:1]);
            `CHK(cs_b, !shadow[0][1] && a[j][9:3] == shadow[2][7:1]);
            `CHK(cs_pri, !dis && a[j][9:3] == 7'h3E && (both || !sec));
            `CHK(cs_sec, !dis && a[j][9:3] == 7'h2E && (both || sec));
        end
    endtask : decode_sweep

    // reset with fresh straps, then every register against its default
    task automatic reset_check();
        @(negedge mclk);
        sys_rst = 1'b1;
        strap = 3'(rnd());
        repeat (3) @(negedge mclk);
        sys_rst = 1'b0;
        repeat (5) @(negedge mclk);
        shadow = '{{7'h0, strap[0]}, 8'hFE, 8'hBE, 8'hE2, 8'h00,
                   {6'h0, strap[1], 1'b0}, {6'h0, strap[2], 1'b0}};
        for (int r = 0; r < 7; r++)
            rd_check(r);
        check_outputs();
    endtask : reset_check

    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    initial
    begin
        reset_check();
        // unmapped index reads zero and drops writes
        HOST.io_write(cfg_bank_pkg::PORT_INDEX, 8'h80, 1'b0);
        HOST.io_write(cfg_bank_pkg::PORT_DATA, 8'h5A, 1'b0);
        HOST.io_read(cfg_bank_pkg::PORT_DATA, d, drv);
        `CHK({drv, d}, 9'h100);
        // index port is write-only, the bus stays undriven
        HOST.io_read(cfg_bank_pkg::PORT_INDEX, d, drv);
        `CHK(drv, 1'b0);
        // a dma cycle must not write the selected register
        HOST.io_write(cfg_bank_pkg::PORT_INDEX, idx_tab[5], 1'b0);
        HOST.io_write(cfg_bank_pkg::PORT_DATA, 8'hFF, 1'b1);
        rd_check(5);
        // every fifo code, dma select and routing code
        for (int c = 0; c < 16; c++)
        begin
            wr(4, {2'h0, 2'(c), 4'(c)});
            wr(3, {4{2'(c)}});
            check_outputs();
        end
        // random register traffic
        for (int i = 0; i < 60; i++)
        begin
            k = int'(rnd() % 7);
            wr(k, 8'(rnd()));
            rd_check(k);
            check_outputs();
            decode_sweep();
        end
        reset_check();
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
